// *** bench/data_mem_model.sv ***
// data memory stand-in on the far side of the indirect address path
// assumes the core clock; read data follows the address at once
`timescale 1ns/1ps
module data_mem_model
(
    input wire logic [8:0] data_addr,
    output logic [7:0] mem_rdata
);
    // pattern from the address, so a stale address shows a wrong byte
    assign mem_rdata = data_addr[7:0] ^ {7'h00, data_addr[8]} ^ 8'h5a;
endmodule

// *** bench/test_program_counter_stack_indirect.sv ***
// self-checking bench for the counter, return stack and indirect path
// assumes pc_core and the data memory model; inputs move at falling edges
`timescale 1ns/1ps
module test_program_counter_stack_indirect;
    import pc_pkg::*;
    logic clk = 0, rst = 1, step_en = 0, latch_we = 0, fsr_we = 0;
    logic indirect_bank_select = 0, data_write = 0, data_we;
    pc_op_t op = PC_OP_HOLD;
    logic [10:0] jump_target = 11'h000;
    logic [12:0] vector_addr = 13'h0000, pc, ret;
    logic [7:0] low_byte_wdata = 8'h00, fsr_wdata = 8'h00, direct_addr = 8'h00;
    logic [7:0] mem_rdata, pc_low_byte, file_select_pointer, read_value;
    logic [4:0] latch_wdata = 5'h00, pc_upper_latch;
    logic [8:0] data_addr;
    // expected return stack; the 3-bit pointer wraps like the real one
    logic [12:0] stk [8];
    logic [2:0] sp = 3'h0;
    int err_count = 0, num_checks = 0;
    pc_core pc_core_i (.clk, .rst, .step_en, .op, .jump_target, .vector_addr, .low_byte_wdata,
        .latch_we, .latch_wdata, .fsr_we, .fsr_wdata, .indirect_bank_select, .direct_addr,
        .data_write, .mem_rdata, .pc, .pc_low_byte, .pc_upper_latch, .file_select_pointer,
        .data_addr, .data_we, .read_value);
    data_mem_model data_mem_model_i (.data_addr, .mem_rdata);
    initial forever #12.5 clk = ~clk;
    task check(input string what, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one operation per call, then an idle edge so strobes never double up
    task run_op(input pc_op_t o, input logic [10:0] t);
        @(negedge clk);
        step_en = 1;
        op = o;
        jump_target = t;
        @(negedge clk);
        step_en = 0;
    endtask
    task set_latch(input logic [4:0] v);
        @(negedge clk);
        latch_we = 1;
        latch_wdata = v;
        @(negedge clk);
        latch_we = 0;
    endtask
    task t_low_write;
        set_latch(5'h15);
        low_byte_wdata = 8'hff;
        run_op(PC_OP_LOW_WRITE, 11'h000);
        check("pc", pc, 13'h15ff);
        check("low", pc_low_byte, 8'hff);
        // wrapped add result: latch must not carry
        low_byte_wdata = 8'h00;
        run_op(PC_OP_LOW_WRITE, 11'h000);
        check("pc", pc, 13'h1500);
        check("latch", pc_upper_latch, 5'h15);
    endtask
    task t_jump;
        set_latch(5'h1a);
        run_op(PC_OP_JUMP, 11'h123);
        check("pc", pc, 13'h1923);
        set_latch(5'h07);
        run_op(PC_OP_CALL, 11'h7ff);
        check("pc", pc, 13'h07ff);
        // reset in mid-run clears the whole counter
        @(negedge clk);
        rst = 1;
        @(negedge clk);
        rst = 0;
        check("pc", pc, 13'h0000);
        check("latch", pc_upper_latch, 5'h00);
    endtask
    task t_stack;
        set_latch(5'h02);
        for (int i = 0; i < 9; i++)
        begin
            stk[sp] = pc + 13'h0001;
            sp++;
            run_op(PC_OP_CALL, 11'h100 + 11'(i));
            check("pc", pc, 13'h0100 + 13'(i));
        end
        // nine pops after nine pushes: the ninth gets the overwritten slot
        for (int i = 0; i < 9; i++)
        begin
            sp--;
            run_op(PC_OP_RETURN, 11'h000);
            check("pc", pc, stk[sp]);
        end
        check("latch", pc_upper_latch, 5'h02);
        vector_addr = 13'h0004;
        ret = pc + 13'h0001;
        run_op(PC_OP_VECTOR, 11'h000);
        check("pc", pc, 13'h0004);
        run_op(PC_OP_RETURN, 11'h000);
        check("pc", pc, ret);
    endtask
    // call and return on consecutive edges, then a plain step and a hold
    task t_back_to_back;
        set_latch(5'h08);
        ret = pc + 13'h0001;
        @(negedge clk);
        step_en = 1;
        op = PC_OP_CALL;
        jump_target = 11'h055;
        @(negedge clk);
        check("pc", pc, 13'h0855);
        op = PC_OP_RETURN;
        @(negedge clk);
        step_en = 0;
        check("pc", pc, ret);
        check("latch", pc_upper_latch, 5'h08);
        run_op(PC_OP_STEP, 11'h000);
        check("pc", pc, ret + 13'h0001);
        run_op(PC_OP_HOLD, 11'h000);
        check("pc", pc, ret + 13'h0001);
    endtask
    task t_indirect;
        @(negedge clk);
        fsr_we = 1;
        fsr_wdata = 8'h5c;
        indirect_bank_select = 1;
        data_write = 1;
        @(negedge clk);
        fsr_we = 0;
        @(negedge clk);
        check("addr", data_addr, 9'h15c);
        check("we", data_we, 1'b1);
        // the model answers the registered address, so its byte lands one edge later
        @(negedge clk);
        check("rd", read_value, 8'h07);
        fsr_we = 1;
        fsr_wdata = 8'h00;
        indirect_bank_select = 0;
        @(negedge clk);
        fsr_we = 0;
        @(negedge clk);
        check("we", data_we, 1'b0);
        check("rd", read_value, 8'h00);
        // a direct file address is never redirected, even with the pointer at zero
        direct_addr = 8'h20;
        @(negedge clk);
        check("addr", data_addr, 9'h020);
        check("we", data_we, 1'b1);
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 0;
        check("pc", pc, 13'h0000);
        check("fsr", file_select_pointer, 8'h00);
        t_low_write();
        $display("low write test done");
        t_jump();
        $display("jump test done");
        t_stack();
        $display("stack test done");
        t_back_to_back();
        $display("back to back test done");
        t_indirect();
        $display("indirect test done");
        complete_run();
    end
    // watchdog: the tests need some 85 cycles
    initial
    begin
        #(2000 * 25);
        err_count++;
        complete_run();
    end
endmodule

// *** rtl/pc_core.sv ***
// top: program counter with upper latch, return stack, indirect addressing
// assumes the decoder drives op, operands and strobes on the core clock
`timescale 1ns/1ps
// Operation
// R01: counter is a thirteen-bit register
// R02: low byte accessible, upper only via latch
// R03: any reset clears whole counter
// R04: low-byte write loads upper from latch
// R05: jump or call takes latch bits 4:3
// R06: low-byte add wraps, no latch carry
// R07: eight by thirteen hidden stack
// R08: call or interrupt vector pushes counter
// R09: returns pop stack into counter
// R10: push and pop leave latch alone
// R11: stack is circular, ninth overwrites first
// R12: no overflow or underflow status
// R13: indirect register redirects via pointer
// R14: self-referencing indirect read gives zero
// R15: self-referencing indirect write stores nothing
// R16: indirect address is bank bit plus pointer
// R17: jump low eleven bits from operand
// R18: excess pops wrap, no error
module pc_core
    import pc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic step_en,
    input wire pc_pkg::pc_op_t op,
    input wire logic [10:0] jump_target,
    input wire logic [12:0] vector_addr,
    input wire logic [7:0] low_byte_wdata,
    input wire logic latch_we,
    input wire logic [4:0] latch_wdata,
    input wire logic fsr_we,
    input wire logic [7:0] fsr_wdata,
    input wire logic indirect_bank_select,
    input wire logic [7:0] direct_addr,
    input wire logic data_write,
    input wire logic [7:0] mem_rdata,
    output logic [12:0] pc,
    output logic [7:0] pc_low_byte,
    output logic [4:0] pc_upper_latch,
    output logic [7:0] file_select_pointer,
    output logic [8:0] data_addr,
    output logic data_we,
    output logic [7:0] read_value
);
    import pc_pkg::*;

    logic [4:0] next_latch;
    logic [12:0] next_pc;
    logic [7:0] next_fsr;
    logic [8:0] comb_addr;
    logic comb_we;
    logic [7:0] comb_read;
    stack_if stk ();

    return_stack u_stack (
        .clk(clk),
        .rst(rst),
        .bus(stk)
    );

    indirect_addr u_indirect (
        .indirect_bank_select(indirect_bank_select),
        .file_select_pointer(file_select_pointer),
        .direct_addr(direct_addr),
        .write_en(data_write),
        .mem_rdata(mem_rdata),
        .data_addr(comb_addr),
        .data_we(comb_we),
        .read_value(comb_read)
    );

    // stack strobes only while the core advances
    always_comb
    begin
        stk.push = step_en && (op == PC_OP_CALL || op == PC_OP_VECTOR); // R08
        stk.pop = step_en && (op == PC_OP_RETURN); // R09
        stk.push_data = pc + 13'h0001;
    end

    // next counter; low-byte path is an 8-bit value so adds wrap by width
    always_comb
    begin
        next_pc = pc;
        if (step_en)
        begin
            case (op)
                PC_OP_STEP: next_pc = pc + 13'h0001;
                PC_OP_HOLD: next_pc = pc;
                PC_OP_JUMP, PC_OP_CALL:
                    next_pc = {pc_upper_latch[JUMP_LATCH_HI:JUMP_LATCH_LO], jump_target}; // R05 R17
                PC_OP_VECTOR: next_pc = vector_addr;
                PC_OP_RETURN: next_pc = stk.top_data; // R09
                PC_OP_LOW_WRITE: next_pc = {pc_upper_latch, low_byte_wdata}; // R04 R06
                default: next_pc = pc;
            endcase
        end
    end

    // latch changes only on its own write; stack traffic never touches it
    always_comb
    begin
        next_latch = latch_we ? latch_wdata : pc_upper_latch; // R02 R10
        next_fsr = fsr_we ? fsr_wdata : file_select_pointer;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pc <= PC_RESET; // R03
            pc_upper_latch <= LATCH_RESET;
            file_select_pointer <= FSR_RESET;
            data_addr <= 9'h000;
            data_we <= 1'b0;
            read_value <= 8'h00;
        end
        else
        begin
            pc <= next_pc; // R01
            pc_upper_latch <= next_latch;
            file_select_pointer <= next_fsr;
            data_addr <= comb_addr;
            data_we <= comb_we;
            read_value <= comb_read;
        end
    end

    // low byte mirrors the counter, registered through pc
    assign pc_low_byte = pc[7:0];

    // reset wins over any operation presented in the same cycle
    chk_reset_clears: assert property (@(posedge clk) // R03
        rst |=> pc == PC_RESET)
        else $error("counter not cleared by reset");
    // all thirteen bits change together on a low-byte write
    chk_low_write_load: assert property (@(posedge clk) disable iff (rst) // R04
        step_en && op == PC_OP_LOW_WRITE |=> pc == {$past(pc_upper_latch), $past(low_byte_wdata)})
        else $error("low write did not load all counter bits");
    chk_jump_bits: assert property (@(posedge clk) disable iff (rst) // R05
        step_en && op == PC_OP_JUMP |=> pc[12:11] == $past(pc_upper_latch[4:3]) && pc[10:0] == $past(jump_target))
        else $error("jump target composed wrongly");
    chk_call_bits: assert property (@(posedge clk) disable iff (rst) // R17
        step_en && op == PC_OP_CALL |=> pc[10:0] == $past(jump_target) && pc[12:11] == $past(pc_upper_latch[4:3]))
        else $error("call target composed wrongly");
    // a plain step carries through all thirteen bits, unlike a low-byte add
    chk_step_count: assert property (@(posedge clk) disable iff (rst) // R01
        step_en && op == PC_OP_STEP |=> pc == $past(pc) + 13'h0001)
        else $error("counter did not advance on step");
    // a latch write alone must never reach the counter's upper bits
    chk_idle_hold: assert property (@(posedge clk) disable iff (rst) // R02
        !step_en |=> $stable(pc))
        else $error("counter moved without an operation");
    chk_vector_load: assert property (@(posedge clk) disable iff (rst) // R08
        step_en && op == PC_OP_VECTOR |=> pc == $past(vector_addr))
        else $error("vector address not loaded");
    chk_return_pop: assert property (@(posedge clk) disable iff (rst) // R09
        step_en && op == PC_OP_RETURN |=> pc == $past(stk.top_data))
        else $error("return did not load the stack top");
    chk_latch_kept: assert property (@(posedge clk) disable iff (rst) // R10
        (stk.push || stk.pop) && !latch_we |=> $stable(pc_upper_latch))
        else $error("stack operation altered latch");
    chk_call_return: assert property (@(posedge clk) disable iff (rst) // R08
        step_en && op == PC_OP_CALL ##1 step_en && op == PC_OP_RETURN |=> pc == $past(pc, 2) + 13'h0001)
        else $error("return did not restore call address");
    // a genuine indirect write must still reach memory
    chk_indirect_write: assert property (@(posedge clk) disable iff (rst) // R13
        data_write && direct_addr == INDIRECT_REG_ADDR && file_select_pointer != INDIRECT_REG_ADDR |=> data_we)
        else $error("indirect write was dropped");
    chk_self_read_zero: assert property (@(posedge clk) disable iff (rst) // R14
        direct_addr == INDIRECT_REG_ADDR && file_select_pointer == INDIRECT_REG_ADDR |=> read_value == 8'h00 && !data_we)
        else $error("self-referencing indirect access not suppressed");
    chk_indirect_addr: assert property (@(posedge clk) disable iff (rst) // R16
        direct_addr == INDIRECT_REG_ADDR |=> data_addr == {$past(indirect_bank_select), $past(file_select_pointer)})
        else $error("indirect address formed wrongly");
endmodule

// *** rtl/pc_pkg.sv ***
// constants for the program counter, return stack and indirect addressing
// assumes a single core clock and synchronous active-high reset
package pc_pkg;
    localparam int PC_WIDTH = 13;
    localparam int BYTE_WIDTH = 8;
    localparam int UPPER_WIDTH = 5;
    localparam int OPERAND_WIDTH = 11;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_WIDTH = 3;
    localparam int DATA_ADDR_WIDTH = 9;
    localparam int JUMP_LATCH_HI = 4;
    localparam int JUMP_LATCH_LO = 3;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [4:0] LATCH_RESET = 5'h00;
    localparam logic [7:0] FSR_RESET = 8'h00;
    localparam logic [2:0] PTR_RESET = 3'h0;
    localparam logic [7:0] INDIRECT_READ_VALUE = 8'h00;
    // address of the virtual register within a data bank (low eight bits)
    localparam logic [7:0] INDIRECT_REG_ADDR = 8'h00;
    // operation codes presented by the instruction decoder
    typedef enum logic [2:0]
    {
        PC_OP_STEP,
        PC_OP_HOLD,
        PC_OP_JUMP,
        PC_OP_CALL,
        PC_OP_VECTOR,
        PC_OP_RETURN,
        PC_OP_LOW_WRITE
    } pc_op_t;
endpackage

// *** rtl/pc_sequencer.sv ***
// indirect-access redirect from the instruction's file address to data memory
// assumes the caller registers the pointer and every output; the bank bit arrives straight from the caller's input
`timescale 1ns/1ps
module indirect_addr
    import pc_pkg::*;
(
    input wire logic indirect_bank_select,
    input wire logic [7:0] file_select_pointer,
    input wire logic [7:0] direct_addr,
    input wire logic write_en,
    input wire logic [7:0] mem_rdata,
    output logic [8:0] data_addr,
    output logic data_we,
    output logic [7:0] read_value
);
    logic self_ref;
    logic is_indirect;

    // virtual register: no storage, redirects through the pointer
    always_comb
    begin
        is_indirect = (direct_addr == INDIRECT_REG_ADDR); // R13
        self_ref = is_indirect && (file_select_pointer == INDIRECT_REG_ADDR);
        data_addr = is_indirect ? {indirect_bank_select, file_select_pointer} // R16
                                : {indirect_bank_select, direct_addr};
        data_we = write_en && !self_ref; // R15
        read_value = self_ref ? INDIRECT_READ_VALUE : mem_rdata; // R14
    end
endmodule

// *** rtl/return_stack.sv ***
// eight-entry circular return-address stack with a hidden pointer
// assumes push and pop never arrive together
`timescale 1ns/1ps
module return_stack
    import pc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    stack_if.store bus
);
    logic [PC_WIDTH-1:0] entries [STACK_DEPTH];
    logic [STACK_PTR_WIDTH-1:0] ptr; // R07 R12
    logic [STACK_PTR_WIDTH-1:0] next_ptr;

    // pointer wraps both ways; no overflow or underflow flag exists
    always_comb
    begin
        next_ptr = ptr;
        if (bus.push)
            next_ptr = ptr + 3'h1; // R11
        else if (bus.pop)
            next_ptr = ptr - 3'h1; // R18
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            ptr <= PTR_RESET;
        else
            ptr <= next_ptr;
    end

    // entries are not reset; a stray pop returns whatever sits there
    always_ff @(posedge clk)
    begin
        if (bus.push)
            entries[ptr + 3'h1] <= bus.push_data; // R07 R11
    end

    assign bus.top_data = entries[ptr]; // R09

    chk_ptr_wraps: assert property (@(posedge clk) disable iff (rst) // R11
        bus.push && !bus.pop |=> ptr == $past(ptr) + 3'h1)
        else $error("stack pointer did not advance on push");
    chk_pop_wraps: assert property (@(posedge clk) disable iff (rst) // R18
        bus.pop && !bus.push |=> ptr == $past(ptr) - 3'h1)
        else $error("stack pointer did not retreat on pop");
    // the pushed address must be the one the next pop would hand back
    chk_push_store: assert property (@(posedge clk) disable iff (rst) // R07
        bus.push |=> entries[ptr] == $past(bus.push_data))
        else $error("pushed address not stored at the new top");
endmodule

// *** rtl/stack_if.sv ***
// push/pop carrier between the sequencer and its return stack
// assumes both ends share the core clock
`timescale 1ns/1ps
interface stack_if;
    logic push;
    logic pop;
    logic [12:0] push_data;
    logic [12:0] top_data;
    modport ctrl (output push, output pop, output push_data, input top_data);
    modport store (input push, input pop, input push_data, output top_data);
endinterface
